// ### hdl/pbmux_pkg.sv
// package: constants and carrier types for the port pin one/zero function selector
package pbmux_pkg;

    // pin function selections
    typedef enum logic [1:0] {
        PBMUX_FN_INPUT   = 2'b00,
        PBMUX_FN_PORT    = 2'b01,
        PBMUX_FN_PATTERN = 2'b10,
        PBMUX_FN_TIMER   = 2'b11
    } pbmux_fn_t;

    // io-control field layout
    localparam int PBMUX_IOC_TOP = 2;
    localparam int PBMUX_IOC_W   = 3;

    // reset values
    localparam logic [2:0] PBMUX_IOC_RST = 3'h0;
    localparam logic       PBMUX_BIT_RST = 1'h0;

    // timer channel 3 settings shared by both pins
    typedef struct packed {
        logic       combined_mode_bit;
        logic       timer3_pwm_mode_bit;
        logic       timer3_a_output_enable;
        logic       timer3_b_output_enable;
        logic [2:0] a_io_control;
        logic [2:0] b_io_control;
    } pbmux_timer_cfg_t;

    // port and pattern settings for the two pins
    typedef struct packed {
        logic pin_one_direction_bit;
        logic pin_zero_direction_bit;
        logic pattern_enable_bit_nine;
        logic pattern_enable_bit_eight;
    } pbmux_port_cfg_t;

    // per-pin output source values
    typedef struct packed {
        logic port_data;
        logic pattern_data;
        logic compare_data;
    } pbmux_src_t;

endpackage

// ### hdl/pbmux_pin_sel.sv
// module: function selection for one pin
`timescale 1ns/100ps
module pbmux_pin_sel (
    input  wire logic                    timer_claim,
    input  wire logic                    capture_allowed,
    input  wire logic                    direction_bit,
    input  wire logic                    pattern_enable,
    input  wire pbmux_pkg::pbmux_src_t   src,
    output      pbmux_pkg::pbmux_fn_t    fn,
    output      logic                    pin_out,
    output      logic                    pin_oe,
    output      logic                    capture_en
);
    always_comb begin
        if (timer_claim) begin
            fn = pbmux_pkg::PBMUX_FN_TIMER;
        end else if (!direction_bit) begin
            fn = pbmux_pkg::PBMUX_FN_INPUT;
        end else if (!pattern_enable) begin
            fn = pbmux_pkg::PBMUX_FN_PORT;
        end else begin
            fn = pbmux_pkg::PBMUX_FN_PATTERN;
        end
    end

    always_comb begin
        case (fn)
            pbmux_pkg::PBMUX_FN_PORT: begin
                pin_out = src.port_data;
            end
            pbmux_pkg::PBMUX_FN_PATTERN: begin
                pin_out = src.pattern_data;
            end
            pbmux_pkg::PBMUX_FN_TIMER: begin
                pin_out = src.compare_data;
            end
            default: begin
                pin_out = 1'h0;
            end
        endcase
    end

    assign pin_oe     = (fn != pbmux_pkg::PBMUX_FN_INPUT);
    assign capture_en = (fn == pbmux_pkg::PBMUX_FN_INPUT) && capture_allowed;
endmodule

// ### hdl/port_b_low_pin_mux.sv
// module: function selector for port pins one and zero
//
// Behaviour
// - pin one chosen from timer, pattern, direction
// - pin zero chosen from timer, pattern, direction
// - pin zero: input, port out, or pattern bit eight
// - pin one: input, port out, or pattern bit nine
// - pin one input feeds b capture conditionally
// - pin zero input feeds a capture conditionally
`timescale 1ns/100ps
module port_b_low_pin_mux (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire pbmux_pkg::pbmux_timer_cfg_t   timer_cfg,
    input  wire pbmux_pkg::pbmux_port_cfg_t    port_cfg,
    input  wire logic                          port_data_one,
    input  wire logic                          port_data_zero,
    input  wire logic                          pattern_out_bit_nine,
    input  wire logic                          pattern_out_bit_eight,
    input  wire logic                          timer3_b_compare_out,
    input  wire logic                          timer3_a_compare_out,
    input  wire logic                          port_pin_one_in,
    input  wire logic                          port_pin_zero_in,
    output      logic                          port_pin_one_out,
    output      logic                          port_pin_one_oe,
    output      logic                          port_pin_zero_out,
    output      logic                          port_pin_zero_oe,
    output      logic                          timer3_b_capture_in,
    output      logic                          timer3_a_capture_in,
    output      logic                          port_pin_one_level,
    output      logic                          port_pin_zero_level,
    output      pbmux_pkg::pbmux_fn_t          pin_one_function,
    output      pbmux_pkg::pbmux_fn_t          pin_zero_function
);
    logic                  b_claim;
    logic                  a_claim;
    logic                  b_cap_ok;
    logic                  a_cap_ok;
    logic                  next_one_out;
    logic                  next_one_oe;
    logic                  next_zero_out;
    logic                  next_zero_oe;
    logic                  one_cap_en;
    logic                  zero_cap_en;
    pbmux_pkg::pbmux_fn_t  next_one_fn;
    pbmux_pkg::pbmux_fn_t  next_zero_fn;
    pbmux_pkg::pbmux_src_t one_src;
    pbmux_pkg::pbmux_src_t zero_src;

    // io-control 0xx other than 000 selects a compare output
    function automatic logic ioc_compare(input logic [2:0] ioc);
        ioc_compare = !ioc[pbmux_pkg::PBMUX_IOC_TOP] && (ioc != pbmux_pkg::PBMUX_IOC_RST);
    endfunction

    // capture allowed when neither combined nor pwm mode and io top bit set
    function automatic logic cap_allowed(input logic [2:0] ioc,
                                         input logic       cmd,
                                         input logic       pwm);
        cap_allowed = !cmd && !pwm && ioc[pbmux_pkg::PBMUX_IOC_TOP];
    endfunction

    // timer claim of pin one, pwm mode leaves it alone
    always_comb begin
        b_claim = 1'h0;
        if (timer_cfg.timer3_b_output_enable) begin
            b_claim = timer_cfg.combined_mode_bit
                      || ioc_compare(timer_cfg.b_io_control);
        end
    end

    // timer claim of pin zero
    always_comb begin
        a_claim = 1'h0;
        if (timer_cfg.timer3_a_output_enable) begin
            a_claim = timer_cfg.combined_mode_bit
                      || timer_cfg.timer3_pwm_mode_bit
                      || ioc_compare(timer_cfg.a_io_control);
        end
    end

    // capture permission of pin one
    always_comb begin
        b_cap_ok = cap_allowed(timer_cfg.b_io_control,
                               timer_cfg.combined_mode_bit,
                               timer_cfg.timer3_pwm_mode_bit);
    end

    // capture permission of pin zero
    always_comb begin
        a_cap_ok = cap_allowed(timer_cfg.a_io_control,
                               timer_cfg.combined_mode_bit,
                               timer_cfg.timer3_pwm_mode_bit);
    end

    // output sources of pin one
    always_comb begin
        one_src.port_data    = port_data_one;
        one_src.pattern_data = pattern_out_bit_nine;
        one_src.compare_data = timer3_b_compare_out;
    end

    // output sources of pin zero
    always_comb begin
        zero_src.port_data    = port_data_zero;
        zero_src.pattern_data = pattern_out_bit_eight;
        zero_src.compare_data = timer3_a_compare_out;
    end

    // pin one selection
    pbmux_pin_sel u_pin_one (
        .timer_claim     (b_claim),
        .capture_allowed (b_cap_ok),
        .direction_bit   (port_cfg.pin_one_direction_bit),
        .pattern_enable  (port_cfg.pattern_enable_bit_nine),
        .src             (one_src),
        .fn              (next_one_fn),
        .pin_out         (next_one_out),
        .pin_oe          (next_one_oe),
        .capture_en      (one_cap_en)
    );

    // pin zero selection
    pbmux_pin_sel u_pin_zero (
        .timer_claim     (a_claim),
        .capture_allowed (a_cap_ok),
        .direction_bit   (port_cfg.pin_zero_direction_bit),
        .pattern_enable  (port_cfg.pattern_enable_bit_eight),
        .src             (zero_src),
        .fn              (next_zero_fn),
        .pin_out         (next_zero_out),
        .pin_oe          (next_zero_oe),
        .capture_en      (zero_cap_en)
    );

    // pin one drive value
    always_ff @(posedge clock) begin
        if (reset) begin
            port_pin_one_out <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            port_pin_one_out <= next_one_out;
        end
    end

    // pin one drive enable
    always_ff @(posedge clock) begin
        if (reset) begin
            port_pin_one_oe <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            port_pin_one_oe <= next_one_oe;
        end
    end

    // pin zero drive value
    always_ff @(posedge clock) begin
        if (reset) begin
            port_pin_zero_out <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            port_pin_zero_out <= next_zero_out;
        end
    end

    // pin zero drive enable
    always_ff @(posedge clock) begin
        if (reset) begin
            port_pin_zero_oe <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            port_pin_zero_oe <= next_zero_oe;
        end
    end

    // pin one function report
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_one_function <= pbmux_pkg::PBMUX_FN_INPUT;
        end else begin
            pin_one_function <= next_one_fn;
        end
    end

    // pin zero function report
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_zero_function <= pbmux_pkg::PBMUX_FN_INPUT;
        end else begin
            pin_zero_function <= next_zero_fn;
        end
    end

    // b capture feed, low unless pin one is a capturing input
    always_ff @(posedge clock) begin
        if (reset) begin
            timer3_b_capture_in <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            timer3_b_capture_in <= one_cap_en && port_pin_one_in;
        end
    end

    // a capture feed, low unless pin zero is a capturing input
    always_ff @(posedge clock) begin
        if (reset) begin
            timer3_a_capture_in <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            timer3_a_capture_in <= zero_cap_en && port_pin_zero_in;
        end
    end

    // pin one level for the port read path
    always_ff @(posedge clock) begin
        if (reset) begin
            port_pin_one_level <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            port_pin_one_level <= port_pin_one_in;
        end
    end

    // pin zero level for the port read path
    always_ff @(posedge clock) begin
        if (reset) begin
            port_pin_zero_level <= pbmux_pkg::PBMUX_BIT_RST;
        end else begin
            port_pin_zero_level <= port_pin_zero_in;
        end
    end
endmodule

// ### tb/pbmux_checker.sv
// checker: pin function selection properties
`timescale 1ns/100ps
module pbmux_checker (
    input wire logic                        clock,
    input wire logic                        reset,
    input wire pbmux_pkg::pbmux_timer_cfg_t timer_cfg,
    input wire pbmux_pkg::pbmux_port_cfg_t  port_cfg,
    input wire logic                        pattern_out_bit_nine,
    input wire logic                        pattern_out_bit_eight,
    input wire logic                        timer3_b_compare_out,
    input wire logic                        timer3_a_compare_out,
    input wire logic                        port_pin_one_in,
    input wire logic                        port_pin_zero_in,
    input wire logic                        port_pin_one_out,
    input wire logic                        port_pin_one_oe,
    input wire logic                        port_pin_zero_out,
    input wire logic                        port_pin_zero_oe,
    input wire logic                        timer3_b_capture_in,
    input wire logic                        timer3_a_capture_in,
    input wire pbmux_pkg::pbmux_fn_t        pin_one_function,
    input wire pbmux_pkg::pbmux_fn_t        pin_zero_function
);
    wire logic cm = timer_cfg.combined_mode_bit;
    wire logic pw = timer_cfg.timer3_pwm_mode_bit;
    wire logic cl1 = timer_cfg.timer3_b_output_enable
        && (cm || timer_cfg.b_io_control inside {3'h1, 3'h2, 3'h3});
    wire logic cl0 = timer_cfg.timer3_a_output_enable
        && (cm || pw || timer_cfg.a_io_control inside {3'h1, 3'h2, 3'h3});
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_one_timer_claim: assert property (!reset && cl1 |=> port_pin_one_oe
        && port_pin_one_out == $past(timer3_b_compare_out)) else $error("pin one claim");
    a_zero_timer_claim: assert property (!reset && cl0 |=> pin_zero_function
        == pbmux_pkg::PBMUX_FN_TIMER && port_pin_zero_oe) else $error("pin zero claim");
    a_zero_input_sel: assert property (!reset && !cl0
        && !port_cfg.pin_zero_direction_bit |=> !port_pin_zero_oe)
        else $error("pin zero not input");
    a_zero_pattern_drive: assert property (!reset && !cl0 && port_cfg[2] && port_cfg[0]
        |=> port_pin_zero_out == $past(pattern_out_bit_eight)) else $error("pattern eight");
    a_one_pattern_drive: assert property (!reset && !cl1 && port_cfg[3] && port_cfg[1]
        |=> port_pin_one_out == $past(pattern_out_bit_nine)) else $error("pattern nine");
    a_b_capture_feed: assert property (##1 timer3_b_capture_in == $past(!reset && !cl1
        && !port_cfg[3] && !cm && !pw && timer_cfg.b_io_control[2] && port_pin_one_in))
        else $error("b capture");
    a_a_capture_feed: assert property (##1 timer3_a_capture_in == $past(!reset && !cl0
        && !port_cfg[2] && !cm && !pw && timer_cfg.a_io_control[2] && port_pin_zero_in))
        else $error("a capture");
endmodule
bind port_b_low_pin_mux pbmux_checker chk_u (.*);

// ### tb/pbmux_board.sv
// partner: board circuitry on the two port pins
`timescale 1ns/100ps
module pbmux_board (
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    input  wire logic [1:0] board_drive,
    output      logic [1:0] pin_level
);
    // a driven pin shows the device value, a released one the board's own changing level
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_drive);
endmodule

// ### tb/port_b_low_pin_mux_bench.sv
// testbench: random configuration sweep against a behavioural selector model
`timescale 1ns/100ps
module port_b_low_pin_mux_bench;
    logic clock = 0, reset = 1;
    pbmux_pkg::pbmux_timer_cfg_t tc = '0;
    pbmux_pkg::pbmux_port_cfg_t pc = '0;
    logic [5:0] src = '0, e1 = '0, e0 = '0;
    logic [1:0] ext = '0, pin, out, oe, cap, lvl, w;
    pbmux_pkg::pbmux_fn_t fn1, fn0;
    int err_total = 0, tests_run = 0, seed = 32'h491FA38D, i;
    always #10 clock = ~clock;
    pbmux_board board_u (.pin_out(out), .pin_oe(oe), .board_drive(ext), .pin_level(pin));
    port_b_low_pin_mux dut_u (.clock(clock), .reset(reset), .timer_cfg(tc), .port_cfg(pc),
        .port_data_one(src[5]), .port_data_zero(src[4]), .pattern_out_bit_nine(src[3]),
        .pattern_out_bit_eight(src[2]), .timer3_b_compare_out(src[1]),
        .timer3_a_compare_out(src[0]), .port_pin_one_in(pin[1]), .port_pin_zero_in(pin[0]),
        .port_pin_one_out(out[1]), .port_pin_one_oe(oe[1]), .port_pin_zero_out(out[0]),
        .port_pin_zero_oe(oe[0]), .timer3_b_capture_in(cap[1]),
        .timer3_a_capture_in(cap[0]), .port_pin_one_level(lvl[1]),
        .port_pin_zero_level(lvl[0]), .pin_one_function(fn1), .pin_zero_function(fn0));
    // model result: function, enable, drive value, capture, level
    function automatic logic [5:0] sel(logic cl, logic cm, logic d, logic pe, logic pt,
        logic dt, logic ck, logic lv);
        pbmux_pkg::pbmux_fn_t f;
        f = cl ? pbmux_pkg::PBMUX_FN_TIMER : !d ? pbmux_pkg::PBMUX_FN_INPUT
            : pe ? pbmux_pkg::PBMUX_FN_PATTERN : pbmux_pkg::PBMUX_FN_PORT;
        return {f, f != pbmux_pkg::PBMUX_FN_INPUT, cl ? cm : pe ? pt : dt,
            f == pbmux_pkg::PBMUX_FN_INPUT && ck && lv, lv};
    endfunction
    task automatic check(logic [5:0] seen, logic [5:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: seen %b want %b", $time, seen, want);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        @(posedge clock);
        for (i = 0; i < 3000; i++) begin
            @(posedge clock);
            reset <= ($random(seed) & 32'h3F) == 32'h0;
            tc <= 10'($random(seed));
            pc <= 4'($random(seed));
            src <= 6'($random(seed));
            ext <= 2'($random(seed));
            @(negedge clock);
            check({fn1, oe[1], out[1] & e1[3], cap[1], lvl[1]},
                {e1[5:3], e1[2] & e1[3], e1[1:0]});
            check({fn0, oe[0], out[0] & e0[3], cap[0], lvl[0]},
                {e0[5:3], e0[2] & e0[3], e0[1:0]});
            w = {e1[3] ? e1[2] : ext[1], e0[3] ? e0[2] : ext[0]};
            e1 = reset ? '0 : sel(tc.timer3_b_output_enable && (tc.combined_mode_bit
                || tc.b_io_control inside {3'h1, 3'h2, 3'h3}), src[1], pc.pin_one_direction_bit,
                pc.pattern_enable_bit_nine, src[3], src[5], !tc.combined_mode_bit
                && !tc.timer3_pwm_mode_bit && tc.b_io_control[2], w[1]);
            e0 = reset ? '0 : sel(tc.timer3_a_output_enable && (tc.combined_mode_bit
                || tc.timer3_pwm_mode_bit || tc.a_io_control inside {3'h1, 3'h2, 3'h3}),
                src[0], pc.pin_zero_direction_bit, pc.pattern_enable_bit_eight, src[2],
                src[4], !tc.combined_mode_bit && !tc.timer3_pwm_mode_bit
                && tc.a_io_control[2], w[0]);
        end
        conclude;
    end
    initial begin
        #100000;
        err_total++;
        conclude;
    end
endmodule
